// ### rtl/trace_trigger_sequencer.sv
// Trigger sequencer, storage and count qualifier of the bus-state analyzer
`timescale 1ns/10ps
module trace_trigger_sequencer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic state_valid,
   input wire logic [trace_seq_pkg::DW-1:0] state_data,
   input wire logic proc_clk_le_16mhz,
   output logic trigger,
   output logic triggered,
   output logic acq_running,
   output logic acq_done
);
   // ==========================================
   // Qualifier evaluation
   function automatic logic qmatch(input logic [1:0] m, input logic [trace_seq_pkg::DW-1:0] v,
                                   input logic [trace_seq_pkg::DW-1:0] mk,
                                   input logic [trace_seq_pkg::DW-1:0] d);
      logic hit;
      hit = ((d ^ v) & mk) == '0;
      unique case (m)
         trace_seq_pkg::Q_NEVER: qmatch = 1'b0;
         trace_seq_pkg::Q_ANY: qmatch = 1'b1;
         trace_seq_pkg::Q_PAT: qmatch = hit;
         trace_seq_pkg::Q_NPAT: qmatch = !hit;
      endcase
   endfunction

   function automatic logic [trace_seq_pkg::TAG_W-1:0] sat_inc(input logic [trace_seq_pkg::TAG_W-1:0] c);
      sat_inc = (c == trace_seq_pkg::TAG_MAX) ? c : c + 16'h0001;
   endfunction

   trace_seq_pkg::st_t s_q, s_d;
   trace_seq_pkg::entry_t mem [0:(1 << trace_seq_pkg::MEM_AW)-1];
   logic [2:0] mem_we;
   logic [2:0][trace_seq_pkg::MEM_AW-1:0] mem_wa;
   trace_seq_pkg::entry_t [2:0] mem_wd;
   trace_seq_pkg::entry_t [2:0] elist;
   trace_seq_pkg::entry_t rd_ent;
   logic [3:0] ctl;
   logic [trace_seq_pkg::MEM_AW:0] lim;
   logic [trace_seq_pkg::MEM_AW-1:0] wmask;
   logic active, searching, m_p, m_r, m_s, m_pre, m_c, brp, brs, trg, sto, cinc;
   logic [1:0] nxt_term;
   logic [1:0] first;
   logic [1:0] nwr;
   logic [trace_seq_pkg::TAG_W-1:0] cnt_nx;
   logic [7:0] wa;

   assign hreadyout = !s_q.rd_wait;
   assign hresp = 1'b0;
   assign hrdata = s_q.hrdata;
   assign trigger = s_q.trig_pls;
   assign triggered = s_q.triggered;
   assign acq_running = s_q.phase != trace_seq_pkg::ACQ_IDLE;
   assign acq_done = s_q.done;
   assign rd_ent = mem[s_q.cfg.mem_idx];

   always_comb begin
      s_d = s_q;
      mem_we = '0;
      mem_wa = '0;
      mem_wd = '0;
      elist = '0;
      ctl = '0;
      nwr = '0;
      wa = s_q.a;
      lim = (s_q.cfg.cnt_mode == trace_seq_pkg::CNT_NONE) ? trace_seq_pkg::DEPTH_FULL
                                                           : trace_seq_pkg::DEPTH_CNT;
      wmask = lim[trace_seq_pkg::MEM_AW-1:0] - 10'h001;
      // ==========================================
      // AHB-Lite slave: zero-wait writes, reads with one wait state
      s_d.wr_pend = 1'b0;
      s_d.rd_wait = 1'b0;
      if (s_q.rd_wait) begin
         s_d.hrdata = '0;
         if (s_q.a >= trace_seq_pkg::A_QUAL) begin
            s_d.hrdata = s_q.a[2] ? s_q.cfg.qmask[s_q.a[5:3]] : s_q.cfg.qval[s_q.a[5:3]];
         end else if (s_q.a >= trace_seq_pkg::A_OCC) begin
            s_d.hrdata = {16'h0000, s_q.cfg.occ[s_q.a[3:2]]};
         end else begin
            unique case (s_q.a)
               trace_seq_pkg::A_STATUS: s_d.hrdata = {22'h000000, s_q.post_cnt[trace_seq_pkg::MEM_AW:0] == lim,
                                                      s_q.cfg.slow, s_q.term, 1'b0, s_q.done, s_q.triggered,
                                                      acq_running, 2'h0};
               trace_seq_pkg::A_TRIG_IDX: s_d.hrdata = {22'h000000, s_q.trig_idx};
               trace_seq_pkg::A_CLK_SEL: s_d.hrdata = {31'h00000000, s_q.cfg.slow};
               trace_seq_pkg::A_CNT_MODE: s_d.hrdata = {30'h00000000, s_q.cfg.cnt_mode};
               trace_seq_pkg::A_NTERMS: s_d.hrdata = {29'h00000000, s_q.cfg.nterms};
               trace_seq_pkg::A_QMODE: s_d.hrdata = {16'h0000, s_q.cfg.qmode};
               trace_seq_pkg::A_MEM_IDX: s_d.hrdata = {22'h000000, s_q.cfg.mem_idx};
               trace_seq_pkg::A_MEM_DATA: s_d.hrdata = rd_ent.data;
               trace_seq_pkg::A_MEM_TAG: s_d.hrdata = {rd_ent.branch, rd_ent.pre, 14'h0000, rd_ent.tag};
               default: s_d.hrdata = '0;
            endcase
         end
      end
      if (hsel && htrans[1] && hready) begin
         s_d.a = {haddr[7:2], 2'b00};
         s_d.wr_pend = hwrite;
         s_d.rd_wait = !hwrite;
      end
      if (s_q.wr_pend) begin
         if (wa >= trace_seq_pkg::A_QUAL) begin
            if (wa[2]) begin
               s_d.cfg.qmask[wa[5:3]] = hwdata;
            end else begin
               s_d.cfg.qval[wa[5:3]] = hwdata;
            end
         end else if (wa >= trace_seq_pkg::A_OCC) begin
            if (hwdata[15:0] != 16'h0000) begin
               s_d.cfg.occ[wa[3:2]] = hwdata[15:0];
            end
         end else begin
            unique case (wa)
               trace_seq_pkg::A_CTRL: ctl = hwdata[3:0];
               trace_seq_pkg::A_CLK_SEL: s_d.cfg.slow = hwdata[0];
               trace_seq_pkg::A_CNT_MODE: begin
                  if (!acq_running) begin
                     if (hwdata[1:0] == trace_seq_pkg::CNT_NONE || hwdata[1:0] == trace_seq_pkg::CNT_STATE) begin
                        s_d.cfg.cnt_mode = trace_seq_pkg::cnt_mode_t'(hwdata[1:0]);
                     end else if (hwdata[1:0] == trace_seq_pkg::CNT_TIME && s_q.cfg.slow && proc_clk_le_16mhz) begin
                        s_d.cfg.cnt_mode = trace_seq_pkg::CNT_TIME;
                     end
                  end
               end
               trace_seq_pkg::A_NTERMS: begin
                  if (hwdata[2:0] != 3'h0 && hwdata[2:0] <= trace_seq_pkg::NTERMS_MAX) begin
                     s_d.cfg.nterms = hwdata[2:0];
                  end
               end
               trace_seq_pkg::A_QMODE: s_d.cfg.qmode = hwdata[15:0];
               trace_seq_pkg::A_MEM_IDX: s_d.cfg.mem_idx = hwdata[trace_seq_pkg::MEM_AW-1:0];
               default: ;
            endcase
         end
      end
      // ==========================================
      // Sequencer
      active = acq_running && state_valid;
      searching = active && s_q.phase == trace_seq_pkg::ACQ_SEARCH;
      // All five conditions judged on the same state
      m_p = qmatch(s_q.cfg.qmode[2*s_q.term +: 2], s_q.cfg.qval[s_q.term], s_q.cfg.qmask[s_q.term],
                   state_data);
      m_r = qmatch(s_q.cfg.qmode[9:8], s_q.cfg.qval[trace_seq_pkg::Q_RESTART],
                   s_q.cfg.qmask[trace_seq_pkg::Q_RESTART], state_data);
      m_s = qmatch(s_q.cfg.qmode[11:10], s_q.cfg.qval[trace_seq_pkg::Q_STORE],
                   s_q.cfg.qmask[trace_seq_pkg::Q_STORE], state_data);
      m_pre = qmatch(s_q.cfg.qmode[13:12], s_q.cfg.qval[trace_seq_pkg::Q_PRE],
                     s_q.cfg.qmask[trace_seq_pkg::Q_PRE], state_data);
      m_c = qmatch(s_q.cfg.qmode[15:14], s_q.cfg.qval[trace_seq_pkg::Q_COUNT],
                   s_q.cfg.qmask[trace_seq_pkg::Q_COUNT], state_data);
      brp = searching && m_p && s_q.occ_left == trace_seq_pkg::OCC_RST;
      brs = searching && m_r && !brp;
      trg = brp && ({1'b0, s_q.term} == s_q.cfg.nterms - 3'h1);
      nxt_term = s_q.term + 2'h1;
      sto = active && (m_s || brp || brs);
      cinc = (s_q.cfg.cnt_mode == trace_seq_pkg::CNT_TIME && acq_running) ||
             (s_q.cfg.cnt_mode == trace_seq_pkg::CNT_STATE && active && m_c);
      cnt_nx = cinc ? sat_inc(s_q.cnt) : s_q.cnt;
      s_d.cnt = cnt_nx;
      s_d.trig_pls = 1'b0;
      if (searching && m_p && !brp) begin
         s_d.occ_left = s_q.occ_left - 16'h0001;
      end
      if (brs) begin
         s_d.term = 2'h0;
         s_d.occ_left = s_q.cfg.occ[0];
      end else if (trg) begin
         s_d.phase = trace_seq_pkg::ACQ_POST;
         s_d.triggered = 1'b1;
         s_d.trig_pls = 1'b1;
      end else if (brp) begin
         s_d.term = nxt_term;
         s_d.occ_left = s_q.cfg.occ[nxt_term];
      end
      // ==========================================
      // Trace memory writes: prestores oldest first, then the state
      first = s_q.pv[0] ? 2'd0 : (s_q.pv[1] ? 2'd1 : 2'd2);
      elist[0] = '{branch: 1'b0, pre: 1'b1, tag: '0, data: s_q.pd[0]};
      elist[1] = '{branch: 1'b0, pre: 1'b1, tag: '0, data: s_q.pd[1]};
      elist[2] = '{branch: brp || brs, pre: 1'b0, tag: cnt_nx, data: state_data};
      if (sto) begin
         for (int j = 0; j < 3; j++) begin
            if (j + int'(first) < 3 &&
                (s_q.phase == trace_seq_pkg::ACQ_SEARCH && !trg ||
                 int'(s_q.post_cnt) + j < int'(lim))) begin
               mem_we[j] = 1'b1;
               mem_wa[j] = (s_q.wp + 10'(j)) & wmask;
               mem_wd[j] = elist[j + int'(first)];
               nwr = nwr + 2'd1;
            end
         end
         if (trg) begin
            s_d.trig_idx = (s_q.wp + 10'(2 - int'(first))) & wmask;
         end
         s_d.wp = (s_q.wp + {8'h00, nwr}) & wmask;
         s_d.pv = 2'b00;
         s_d.cnt = '0;
         if (s_q.phase == trace_seq_pkg::ACQ_POST || trg) begin
            s_d.post_cnt = s_q.post_cnt + {9'h000, nwr};
         end
      end else if (active && m_pre) begin
         s_d.pv = {1'b1, s_q.pv[1]};
         s_d.pd = {state_data, s_q.pd[1]};
      end
      if ((s_q.phase == trace_seq_pkg::ACQ_POST || trg) && s_d.post_cnt >= lim) begin
         s_d.phase = trace_seq_pkg::ACQ_IDLE;
         s_d.done = 1'b1;
      end
      // ==========================================
      // Control commands
      if (ctl[trace_seq_pkg::C_HALT]) begin
         s_d.phase = trace_seq_pkg::ACQ_IDLE;
      end
      if (ctl[trace_seq_pkg::C_SEQ_RST]) begin
         s_d.cfg.nterms = trace_seq_pkg::NTERMS_RST;
         s_d.cfg.qmode = (s_d.cfg.qmode & ~trace_seq_pkg::QMODE_SEQ_MASK) |
                         (trace_seq_pkg::QMODE_RST & trace_seq_pkg::QMODE_SEQ_MASK);
         s_d.cfg.occ = trace_seq_pkg::ST_RST.cfg.occ;
      end
      if (ctl[trace_seq_pkg::C_INIT]) begin
         s_d.cfg = trace_seq_pkg::ST_RST.cfg;
         s_d.phase = trace_seq_pkg::ACQ_IDLE;
         s_d.triggered = 1'b0;
         s_d.done = 1'b0;
      end
      if (ctl[trace_seq_pkg::C_START] && !ctl[trace_seq_pkg::C_HALT] && !ctl[trace_seq_pkg::C_INIT] &&
          !acq_running) begin
         s_d.phase = trace_seq_pkg::ACQ_SEARCH;
         s_d.term = 2'h0;
         s_d.occ_left = s_d.cfg.occ[0];
         s_d.cnt = '0;
         s_d.wp = '0;
         s_d.post_cnt = '0;
         s_d.pv = 2'b00;
         s_d.triggered = 1'b0;
         s_d.done = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= trace_seq_pkg::ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge hclk) begin
      for (int j = 0; j < 3; j++) begin
         if (mem_we[j]) begin
            mem[mem_wa[j]] <= mem_wd[j];
         end
      end
   end

   // ==========================================
   // Checks
   init_cnt_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctl[trace_seq_pkg::C_INIT] |=> s_q.cfg.cnt_mode == trace_seq_pkg::CNT_NONE && s_q.cfg.nterms == 3'h1)
      else $error("count qualifier not off after init");
   cnt_depth_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (|mem_we) && s_q.cfg.cnt_mode != trace_seq_pkg::CNT_NONE |->
      mem_wa[0] < 10'h200 && mem_wa[1] < 10'h200 && mem_wa[2] < 10'h200)
      else $error("write beyond 512 entries while counting");
   post_fill_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.post_cnt <= 11'h400)
      else $error("more than 1024 entries after trigger");
   state_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.cfg.cnt_mode == trace_seq_pkg::CNT_STATE && active && m_c && !sto && !(|ctl) && s_q.cnt != 16'hffff
      |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
      else $error("state count missed");
   time_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_d.cfg.cnt_mode == trace_seq_pkg::CNT_TIME && s_q.cfg.cnt_mode != trace_seq_pkg::CNT_TIME
      |-> s_q.cfg.slow && proc_clk_le_16mhz)
      else $error("time counting without slow clock");
   advance_a: assert property (@(posedge hclk) disable iff (!hresetn)
      brp && !trg && !(|ctl) |=> s_q.term == $past(nxt_term) && s_q.occ_left == s_q.cfg.occ[s_q.term])
      else $error("primary branch did not advance and reload");
   restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
      brs && !(|ctl) |=> s_q.term == 2'h0 && s_q.occ_left == s_q.cfg.occ[0])
      else $error("restart did not return to term one");
   trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
      trg && !(|ctl) |=> trigger && triggered ##1 !trigger)
      else $error("trigger pulse wrong");
   branch_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (brp || brs) && !trg |-> mem_we[2 - int'(first)] && mem_wd[2 - int'(first)].branch)
      else $error("branch state not stored");
   full_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.phase == trace_seq_pkg::ACQ_POST && s_d.post_cnt >= lim && !(|ctl) |=> !acq_running && acq_done)
      else $error("acquisition did not stop when full");
   seq_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctl[trace_seq_pkg::C_SEQ_RST] |=> s_q.cfg.nterms == 3'h1 && s_q.cfg.qmode[1:0] == 2'h1 &&
      s_q.cfg.qmode[9:8] == 2'h0)
      else $error("sequencer reset left wrong defaults");
   // ==========================================
   // Configuration, sequencer and storage checks
   count_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.cfg.cnt_mode == trace_seq_pkg::CNT_NONE |=> s_q.cnt == $past(s_q.cnt) || s_q.cnt == 16'h0000)
      else $error("count moved while counting is off");
   depth_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.phase == trace_seq_pkg::ACQ_POST && s_q.cfg.cnt_mode == trace_seq_pkg::CNT_NONE &&
      s_d.post_cnt < 11'h400 && !(|ctl) |=> acq_running)
      else $error("acquisition stopped before 1024 entries");
   any_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
      searching && s_q.term == 2'h0 && s_q.cfg.nterms == 3'h1 && s_q.occ_left == 16'h0001 &&
      s_q.cfg.qmode[1:0] == trace_seq_pkg::Q_ANY && !(|ctl) |=> trigger)
      else $error("any condition missed a state");
   restart_never_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.cfg.qmode[9:8] == trace_seq_pkg::Q_NEVER |-> !brs)
      else $error("restart taken with condition never");
   store_all_a: assert property (@(posedge hclk) disable iff (!hresetn)
      active && s_q.phase == trace_seq_pkg::ACQ_SEARCH && s_q.cfg.qmode[11:10] == trace_seq_pkg::Q_ANY |->
      mem_we != 3'h0)
      else $error("state not stored with store qualifier any");
   prestore_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sto && s_q.pv == 2'b11 && mem_we == 3'b111 |->
      mem_wd[0].pre && mem_wd[1].pre && !mem_wd[2].pre && mem_wd[2].data == state_data)
      else $error("prestore entries out of order");
   occ_legal_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.cfg.occ[0] != 16'h0000 && s_q.cfg.occ[1] != 16'h0000 && s_q.cfg.occ[2] != 16'h0000 &&
      s_q.cfg.occ[3] != 16'h0000)
      else $error("occurrence count of zero");
   term_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.cfg.nterms != 3'h0 && s_q.cfg.nterms <= trace_seq_pkg::NTERMS_MAX)
      else $error("term count out of range");
   tag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sto && !(|ctl) |=> s_q.cnt == 16'h0000)
      else $error("count tag not restarted after a store");
   frozen_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.phase == trace_seq_pkg::ACQ_POST && !(|ctl) |=> triggered && s_q.term == $past(s_q.term))
      else $error("sequencer moved after trigger");
   post_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.phase == trace_seq_pkg::ACQ_POST && sto && s_q.post_cnt < lim |-> mem_we[0])
      else $error("qualified state dropped before memory full");
   idle_nowrite_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !acq_running |-> mem_we == 3'h0)
      else $error("memory written while stopped");
   init_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctl[trace_seq_pkg::C_INIT] |=> s_q.cfg.qmode == trace_seq_pkg::QMODE_RST &&
      s_q.cfg.occ[0] == trace_seq_pkg::OCC_RST)
      else $error("init left wrong sequencer defaults");
endmodule

// ### common/trace_seq_pkg.sv
// Constants, register map and state types of the trace trigger sequencer
package trace_seq_pkg;
   // ==========================================
   // Widths and depths
   localparam int DW = 32;
   localparam int TAG_W = 16;
   localparam int OCC_W = 16;
   localparam int MEM_AW = 10;
   localparam logic [MEM_AW:0] DEPTH_FULL = 11'h400;
   localparam logic [MEM_AW:0] DEPTH_CNT = 11'h200;
   localparam logic [TAG_W-1:0] TAG_MAX = 16'hffff;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_TRIG_IDX = 8'h08;
   localparam logic [7:0] A_CLK_SEL = 8'h0c;
   localparam logic [7:0] A_CNT_MODE = 8'h10;
   localparam logic [7:0] A_NTERMS = 8'h14;
   localparam logic [7:0] A_QMODE = 8'h18;
   localparam logic [7:0] A_MEM_IDX = 8'h1c;
   localparam logic [7:0] A_MEM_DATA = 8'h20;
   localparam logic [7:0] A_MEM_TAG = 8'h24;
   localparam logic [7:0] A_OCC = 8'h30;
   localparam logic [7:0] A_QUAL = 8'h40;
   // Control bits
   localparam int C_START = 0;
   localparam int C_HALT = 1;
   localparam int C_INIT = 2;
   localparam int C_SEQ_RST = 3;
   // ==========================================
   // Qualifier modes and slots
   localparam logic [1:0] Q_NEVER = 2'h0;
   localparam logic [1:0] Q_ANY = 2'h1;
   localparam logic [1:0] Q_PAT = 2'h2;
   localparam logic [1:0] Q_NPAT = 2'h3;
   localparam int Q_RESTART = 4;
   localparam int Q_STORE = 5;
   localparam int Q_PRE = 6;
   localparam int Q_COUNT = 7;
   localparam logic [15:0] QMODE_RST = 16'h0455;
   localparam logic [15:0] QMODE_SEQ_MASK = 16'h03ff;
   localparam logic [OCC_W-1:0] OCC_RST = 16'h0001;
   localparam logic [2:0] NTERMS_RST = 3'h1;
   localparam logic [2:0] NTERMS_MAX = 3'h4;
   // ==========================================
   // Types
   typedef enum logic [1:0] {CNT_NONE = 2'h0, CNT_STATE = 2'h1, CNT_TIME = 2'h2} cnt_mode_t;
   typedef enum logic [2:0] {ACQ_IDLE = 3'b001, ACQ_SEARCH = 3'b010, ACQ_POST = 3'b100} acq_t;
   typedef struct packed {
      logic branch;
      logic pre;
      logic [TAG_W-1:0] tag;
      logic [DW-1:0] data;
   } entry_t;
   typedef struct packed {
      cnt_mode_t cnt_mode;
      logic slow;
      logic [2:0] nterms;
      logic [15:0] qmode;
      logic [7:0][DW-1:0] qval;
      logic [7:0][DW-1:0] qmask;
      logic [3:0][OCC_W-1:0] occ;
      logic [MEM_AW-1:0] mem_idx;
   } cfg_t;
   typedef struct packed {
      cfg_t cfg;
      acq_t phase;
      logic trig_pls;
      logic triggered;
      logic done;
      logic [1:0] term;
      logic [OCC_W-1:0] occ_left;
      logic [TAG_W-1:0] cnt;
      logic [1:0] pv;
      logic [1:0][DW-1:0] pd;
      logic [MEM_AW-1:0] wp;
      logic [MEM_AW:0] post_cnt;
      logic [MEM_AW-1:0] trig_idx;
      logic wr_pend;
      logic rd_wait;
      logic [7:0] a;
      logic [31:0] hrdata;
   } st_t;
   function automatic st_t st_reset();
      st_t s;
      s = '0;
      s.phase = ACQ_IDLE;
      s.cfg.cnt_mode = CNT_NONE;
      s.cfg.nterms = NTERMS_RST;
      s.cfg.qmode = QMODE_RST;
      for (int i = 0; i < 4; i++) begin
         s.cfg.occ[i] = OCC_RST;
      end
      return s;
   endfunction
   localparam st_t ST_RST = st_reset();
endpackage

// ### testbench/bus_state_source.sv
// Model of the emulated target that feeds captured bus states
`timescale 1ns/10ps
module bus_state_source (
   input wire logic hclk,
   output logic state_valid,
   output logic [31:0] state_data
);
   initial begin
      state_valid = 1'b0;
      state_data = 32'h0;
   end
   // ==========================================
   // Sends n states d, d+s, d+2s ... back to back, one per clock
   task automatic send(input int n, input logic [31:0] d, input logic [31:0] s);
      for (int i = 0; i < n; i++) begin
         @(posedge hclk);
         state_valid <= 1'b1;
         state_data <= d + s * 32'(i);
      end
      @(posedge hclk);
      state_valid <= 1'b0;
      // Idle bus never repeats the last state
      state_data <= ~state_data;
      @(negedge hclk);
   endtask
endmodule

// ### testbench/trace_trigger_sequencer_bench.sv
// Self-checking bench of the trace trigger sequencer
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module trace_trigger_sequencer_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic proc_slow = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, state_data, rd;
   logic hreadyout, hresp, state_valid, trigger, triggered, acq_running, acq_done;
   int errors = 0;
   int checks_done = 0;
   int trig_cnt = 0;
   int lim;
   always #5 hclk = ~hclk;
   always @(posedge hclk) if (trigger === 1'b1) trig_cnt <= trig_cnt + 1;
   trace_trigger_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .state_valid(state_valid),
      .state_data(state_data), .proc_clk_le_16mhz(proc_slow), .trigger(trigger),
      .triggered(triggered), .acq_running(acq_running), .acq_done(acq_done));
   bus_state_source i_src (.hclk(hclk), .state_valid(state_valid), .state_data(state_data));
   // ==========================================
   // Closing report
   task automatic test_done();
      $display("Checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========================================
   // AHB-Lite single word transfer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      rd = hrdata;
      if (n >= 20) begin
         errors++;
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
      xfer(1'b0, a, 32'h0);
      `CHECK($sformatf("reg %h", a), ex, rd)
      `CHECK("hresp", 1'b0, hresp)
   endtask
   task automatic setq(input int slot, input logic [31:0] v);
      wr(8'(8'h40 + 8 * slot), v);
      wr(8'(8'h44 + 8 * slot), 32'hffffffff);
   endtask
   task automatic memc(input logic [9:0] i, input logic [31:0] d);
      wr(trace_seq_pkg::A_MEM_IDX, {22'h0, i});
      rdc(trace_seq_pkg::A_MEM_DATA, d);
   endtask
   // ==========================================
   // Watchdog
   initial begin
      repeat (100000) @(posedge hclk);
      errors++;
      test_done();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(trace_seq_pkg::A_CNT_MODE, 32'h0);
      rdc(trace_seq_pkg::A_QMODE, 32'h455);
      rdc(8'h28, 32'h0);
      wr(trace_seq_pkg::A_NTERMS, 32'h5);
      rdc(trace_seq_pkg::A_NTERMS, 32'h1);
      wr(trace_seq_pkg::A_OCC, 32'h0);
      rdc(trace_seq_pkg::A_OCC, 32'h1);
      wr(trace_seq_pkg::A_OCC, 32'hffff);
      rdc(trace_seq_pkg::A_OCC, 32'hffff);
      wr(trace_seq_pkg::A_CNT_MODE, 32'h2);
      rdc(trace_seq_pkg::A_CNT_MODE, 32'h0);
      wr(trace_seq_pkg::A_CLK_SEL, 32'h1);
      wr(trace_seq_pkg::A_CNT_MODE, 32'h2);
      rdc(trace_seq_pkg::A_CNT_MODE, 32'h0);
      $display("Test config done");
      proc_slow <= 1'b1;
      // Fill memory in each counting mode from the default setup
      for (int m = 0; m < 3; m++) begin
         lim = (m == 0) ? 1024 : 512;
         wr(trace_seq_pkg::A_CTRL, 32'h4);
         wr(trace_seq_pkg::A_CLK_SEL, 32'h1);
         wr(trace_seq_pkg::A_CNT_MODE, 32'(m));
         rdc(trace_seq_pkg::A_CNT_MODE, 32'(m));
         wr(trace_seq_pkg::A_CTRL, 32'h1);
         i_src.send(1, 32'h1000, 32'h0);
         `CHECK("triggered", 1'b1, triggered)
         memc(10'h0, 32'h1000);
         xfer(1'b0, trace_seq_pkg::A_MEM_TAG, 32'h0);
         `CHECK("branch bit", 1'b1, rd[31])
         i_src.send(lim - 2, 32'h2000, 32'h1);
         `CHECK("done early", 1'b0, acq_done)
         i_src.send(1, 32'h3000, 32'h0);
         `CHECK("done", 1'b1, acq_done)
         `CHECK("running", 1'b0, acq_running)
         $display("Test fill mode %0d done", m);
      end
      `CHECK("trigger pulses", 3, trig_cnt)
      // Two terms, occurrence count 2 in term two, restart in between
      wr(trace_seq_pkg::A_CTRL, 32'h4);
      wr(trace_seq_pkg::A_NTERMS, 32'h2);
      wr(trace_seq_pkg::A_QMODE, 32'h025a);
      setq(0, 32'ha0);
      setq(1, 32'hb0);
      setq(4, 32'hc0);
      wr(8'h34, 32'h2);
      wr(trace_seq_pkg::A_CTRL, 32'h1);
      i_src.send(1, 32'ha0, 32'h0);
      rdc(trace_seq_pkg::A_STATUS, 32'h44);
      i_src.send(1, 32'hb0, 32'h0);
      rdc(trace_seq_pkg::A_STATUS, 32'h44);
      i_src.send(1, 32'hc0, 32'h0);
      rdc(trace_seq_pkg::A_STATUS, 32'h04);
      i_src.send(1, 32'ha0, 32'h0);
      i_src.send(1, 32'hb0, 32'h0);
      `CHECK("no trigger yet", 1'b0, triggered)
      i_src.send(1, 32'hb0, 32'h0);
      `CHECK("trigger", 1'b1, triggered)
      rdc(trace_seq_pkg::A_TRIG_IDX, 32'h3);
      memc(10'h1, 32'hc0);
      memc(10'h3, 32'hb0);
      wr(trace_seq_pkg::A_CTRL, 32'h8);
      rdc(trace_seq_pkg::A_NTERMS, 32'h1);
      rdc(trace_seq_pkg::A_QMODE, 32'h0055);
      rdc(8'h34, 32'h1);
      $display("Test sequencer done");
      // Prestore with state counting
      wr(trace_seq_pkg::A_CTRL, 32'h4);
      wr(trace_seq_pkg::A_CNT_MODE, 32'h1);
      wr(trace_seq_pkg::A_QMODE, 32'h5856);
      setq(0, 32'hd0);
      setq(5, 32'hd0);
      wr(trace_seq_pkg::A_CTRL, 32'h1);
      i_src.send(1, 32'hd0, 32'h0);
      i_src.send(3, 32'he1, 32'h1);
      i_src.send(1, 32'hd0, 32'h0);
      memc(10'h1, 32'he2);
      rdc(trace_seq_pkg::A_MEM_TAG, 32'h40000000);
      memc(10'h2, 32'he3);
      memc(10'h3, 32'hd0);
      rdc(trace_seq_pkg::A_MEM_TAG, 32'h4);
      $display("Test prestore done");
      // Halt keeps the trigger flag; then trigger on a state off the pattern
      wr(trace_seq_pkg::A_CTRL, 32'h2);
      rdc(trace_seq_pkg::A_STATUS, 32'h08);
      wr(trace_seq_pkg::A_CTRL, 32'h4);
      wr(trace_seq_pkg::A_QMODE, 32'h0457);
      setq(0, 32'hf0);
      wr(trace_seq_pkg::A_CTRL, 32'h1);
      i_src.send(1, 32'hf0, 32'h0);
      `CHECK("no trigger on pattern", 1'b0, triggered)
      i_src.send(1, 32'hf1, 32'h0);
      `CHECK("trigger off pattern", 1'b1, triggered)
      $display("Test halt and mismatch done");
      test_done();
   end
endmodule
